/* asis_pkg.sv */
/*
  constants, field positions and carrier types for the asynchronous serial
  interrupt status block. assumes one 125 MHz core clock and an APB master
  with 32-bit data; register indices are word indices.
*/
`default_nettype none
package asis_pkg;
  // word indices; byte address is four times the index
  localparam logic [7:0] RX_STATUS_IDX = 8'h3a; // read: status, write: mask
  localparam logic [7:0] TX_STATUS_IDX = 8'h3b; // read: status, write: mask
  localparam logic [7:0] CONFIG_IDX    = 8'h30; // mode and flow characters
  localparam logic [7:0] CHARCFG_IDX   = 8'h31; // termination char, level
  localparam logic [7:0] LINE_IDX      = 8'h32; // line levels, read only
  localparam int         PADDR_W       = 10;
  localparam logic [PADDR_W-1:0] RX_STATUS_ADDR = {RX_STATUS_IDX, 2'b00};
  localparam logic [PADDR_W-1:0] TX_STATUS_ADDR = {TX_STATUS_IDX, 2'b00};
  localparam logic [PADDR_W-1:0] CONFIG_ADDR    = {CONFIG_IDX, 2'b00};
  localparam logic [PADDR_W-1:0] CHARCFG_ADDR   = {CHARCFG_IDX, 2'b00};
  localparam logic [PADDR_W-1:0] LINE_ADDR      = {LINE_IDX, 2'b00};

  // reset values
  localparam logic [7:0]  STATUS_RST  = 8'h00;
  localparam logic [7:0]  MASK_RST    = 8'hff;
  localparam logic [31:0] CONFIG_RST  = 32'h0000_0a00;
  localparam logic [31:0] CHARCFG_RST = 32'h0000_2000;

  // receive status bit positions
  localparam int RX_TERM = 7;
  localparam int RX_TOUT = 6;
  localparam int RX_PARITY_ERROR_FLAG = 5;
  localparam int RX_FRAMING_ERROR_FLAG = 4;
  localparam int RX_PLL  = 3;
  localparam int RX_CD   = 2;
  localparam int RX_OVF  = 1;
  localparam int RX_POOL = 0;
  // line/transmit status bit positions
  localparam int TX_BRK  = 7;
  localparam int TX_BRKE = 6;
  localparam int TX_ALL_SENT = 5;
  localparam int TX_STOP = 4;
  localparam int TX_TMR  = 3;
  localparam int TX_CTS  = 2;
  localparam int TX_RES  = 1;
  localparam int TX_POOL = 0;

  // config register fields
  localparam int CFG_VIS     = 0;
  localparam int CFG_PAR_EN  = 1;
  localparam int CFG_SBYTE   = 2;
  localparam int CFG_IRQMODE = 3;
  localparam int CFG_DPLL    = 4;
  localparam int CFG_TXDPLL  = 5;
  localparam int CFG_FLEN_LO = 8;  // frame length in bits, 4 bits wide
  localparam int CFG_STOP_LO = 16; // stop character
  localparam int CFG_RES_LO  = 24; // resume character
  // character config fields
  localparam int CC_TERM_LO  = 0;  // termination character
  localparam int CC_THR_LO   = 8;  // receive threshold, 6 bits
  localparam int CC_TERM_EN  = 16;

  // timeout is this many character frames
  localparam int TIMEOUT_FRAMES = 4;

  typedef struct packed {
    logic       char_valid;      // one-cycle pulse per received character
    logic [7:0] char_data;
    logic       parity_bad;      // qualifies char_valid
    logic       stop_zero;       // qualifies char_valid
    logic       fifo_full;       // level
    logic [5:0] fifo_level;      // level, entries incl. status bytes
    logic       frame_read_done; // pulse
    logic       pll_lost;        // level
  } asis_rx_evt_t;

  typedef struct packed {
    logic fifo_empty;    // level
    logic shift_idle;    // level
    logic timer_expired; // pulse
    logic pool_ready;    // pulse: room for a 32-byte block
  } asis_tx_evt_t;

  typedef struct packed {
    logic term; // vector for termination output
    logic receive_pool_full;  // vector for receive pool full output
    logic transmit_pool_ready;  // vector for transmit pool ready output
  } asis_vec_ack_t;

  typedef struct packed {
    logic valid;
    logic parity_err;
    logic framing_err;
  } asis_fifo_stat_t;
endpackage : asis_pkg
`default_nettype wire

/* asis_top.sv */
/*
  interrupt status registers of one asynchronous serial channel, with
  their masks, the event detectors that feed them and an APB slave.
  assumes receiver, fifo and timer logic on the same clock deliver the
  event structs, and that bit_tick_i is a one-cycle pulse per bit time.
*/
`timescale 1ns/1ps
`default_nettype none
module asis_top (
  input  wire logic                     clk_i,
  input  wire logic                     rstn_i,
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [asis_pkg::PADDR_W-1:0] paddr_i,
  input  wire logic [31:0]              pwdata_i,
  input  wire logic [3:0]               pstrb_i,
  output logic [31:0]                   prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  input  wire logic                     bit_tick_i,
  input  wire logic                     rxd_i,
  input  wire logic                     cd_i,
  input  wire logic                     cts_i,
  input  wire asis_pkg::asis_rx_evt_t   rx_evt_i,
  input  wire asis_pkg::asis_tx_evt_t   tx_evt_i,
  input  wire asis_pkg::asis_vec_ack_t  vec_ack_i,
  output asis_pkg::asis_fifo_stat_t     fifo_stat_o,
  output logic                          rx_disable_o,
  output logic                          tx_halt_o,
  output logic [1:0]                    global_status_o,
  output logic                          irq_o
);
  import asis_pkg::*;

  // register state
  logic [7:0]  rx_stat_reg, rx_stat_next;
  logic [7:0]  tx_stat_reg, tx_stat_next;
  logic [7:0]  rx_mask_reg, rx_mask_next;
  logic [7:0]  tx_mask_reg, tx_mask_next;
  logic [31:0] cfg_reg,     cfg_next;
  logic [31:0] ccfg_reg,    ccfg_next;
  logic [31:0] rdata_reg,   rdata_next;
  logic        err_reg,     err_next;
  // line synchronisers and edge history
  logic [2:0]  sync1_reg, sync2_reg, prev_reg;
  // detectors
  logic [5:0]  tout_cnt_reg, tout_cnt_next;
  logic        tout_arm_reg, tout_arm_next;
  logic [3:0]  brk_cnt_reg,  brk_cnt_next;
  logic        in_brk_reg,   in_brk_next;
  logic        pll_prev_reg, all_sent_prev_reg;
  logic [5:0]  lvl_prev_reg;
  asis_fifo_stat_t fstat_reg, fstat_next;

  // decoded fields and strobes
  logic        masked_status_visible, par_en, sbyte_en, irq_mode, dpll, tx_dpll, term_en;
  logic [3:0]  flen;
  logic [7:0]  stop_ch, res_ch, term_ch;
  logic [5:0]  thr;
  logic        rxd_s, cd_s, cts_s;
  logic        setup, access_rd, access_wr;
  logic        rd_rx, rd_tx;
  logic [7:0]  rx_set, tx_set, rx_vis, tx_vis;
  logic        all_sent_now, brk_hit;

  assign masked_status_visible      = cfg_reg[CFG_VIS];
  assign par_en   = cfg_reg[CFG_PAR_EN];
  assign sbyte_en = cfg_reg[CFG_SBYTE];
  assign irq_mode = cfg_reg[CFG_IRQMODE];
  assign dpll     = cfg_reg[CFG_DPLL];
  assign tx_dpll  = cfg_reg[CFG_TXDPLL];
  assign flen     = cfg_reg[CFG_FLEN_LO +: 4];
  assign stop_ch  = cfg_reg[CFG_STOP_LO +: 8];
  assign res_ch   = cfg_reg[CFG_RES_LO +: 8];
  assign term_ch  = ccfg_reg[CC_TERM_LO +: 8];
  assign thr      = ccfg_reg[CC_THR_LO +: 6];
  assign term_en  = ccfg_reg[CC_TERM_EN];
  assign rxd_s    = sync2_reg[0];
  assign cd_s     = sync2_reg[1];
  assign cts_s    = sync2_reg[2];

  // apb phase decode; slave is always ready
  assign setup     = psel_i & ~penable_i;
  assign access_rd = psel_i & penable_i & ~pwrite_i;
  assign access_wr = psel_i & penable_i & pwrite_i;
  assign rd_rx     = access_rd & (paddr_i == RX_STATUS_ADDR);
  assign rd_tx     = access_rd & (paddr_i == TX_STATUS_ADDR);
  assign pready_o  = 1'b1;

  // pins cross in through two flip-flops, reset to the idle high level
  // so that no false change flag follows reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
      prev_reg  <= 3'h7;
    end else begin
      sync1_reg <= {cts_i, cd_i, rxd_i};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // break and timeout counters, counted in bit ticks
  always_comb begin
    tout_cnt_next = tout_cnt_reg;
    tout_arm_next = tout_arm_reg;
    brk_cnt_next  = brk_cnt_reg;
    in_brk_next   = in_brk_reg;
    brk_hit       = 1'b0;
    if (rx_evt_i.char_valid) begin
      tout_arm_next = 1'b1;
      tout_cnt_next = 6'h00;
    end else if (tout_arm_reg && bit_tick_i) begin
      if (tout_cnt_reg == 6'(TIMEOUT_FRAMES * flen) - 6'h01) begin
        tout_arm_next = 1'b0;
      end
      tout_cnt_next = tout_cnt_reg + 6'h01;
    end
    // low line for data, parity and stop bits
    if (rxd_s) begin
      brk_cnt_next = 4'h0;
      in_brk_next  = 1'b0;
    end else if (bit_tick_i && !in_brk_reg) begin
      if (brk_cnt_reg == flen - 4'h2) begin
        brk_hit     = 1'b1;
        in_brk_next = 1'b1;
      end
      brk_cnt_next = brk_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tout_cnt_reg <= 6'h00;
      tout_arm_reg <= 1'b0;
      brk_cnt_reg  <= 4'h0;
      in_brk_reg   <= 1'b0;
    end else begin
      tout_cnt_reg <= tout_cnt_next;
      tout_arm_reg <= tout_arm_next;
      brk_cnt_reg  <= brk_cnt_next;
      in_brk_reg   <= in_brk_next;
    end
  end

  // level history for edge detection
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pll_prev_reg  <= 1'b0;
      all_sent_prev_reg <= 1'b1;
      lvl_prev_reg  <= 6'h00;
    end else begin
      pll_prev_reg  <= rx_evt_i.pll_lost;
      all_sent_prev_reg <= all_sent_now;
      lvl_prev_reg  <= rx_evt_i.fifo_level;
    end
  end

  assign all_sent_now = tx_evt_i.fifo_empty & tx_evt_i.shift_idle;

  // event set terms
  always_comb begin
    rx_set = 8'h00;
    tx_set = 8'h00;
    // termination character or frame read done
    rx_set[RX_TERM] = rx_evt_i.frame_read_done |
                      (rx_evt_i.char_valid & term_en &
                       (rx_evt_i.char_data == term_ch));
    rx_set[RX_TOUT] = tout_arm_reg & bit_tick_i & ~rx_mask_reg[RX_TOUT] &
                      ~rx_evt_i.char_valid &
                      (tout_cnt_reg == 6'(TIMEOUT_FRAMES * flen) - 6'h01);
    rx_set[RX_PARITY_ERROR_FLAG] = rx_evt_i.char_valid & par_en & rx_evt_i.parity_bad;
    rx_set[RX_FRAMING_ERROR_FLAG] = rx_evt_i.char_valid & rx_evt_i.stop_zero;
    // rising loss of lock in coded dpll mode
    rx_set[RX_PLL]  = dpll & rx_evt_i.pll_lost & ~pll_prev_reg;
    rx_set[RX_CD]   = cd_s ^ prev_reg[1];
    rx_set[RX_OVF]  = rx_evt_i.char_valid & rx_evt_i.fifo_full;
    rx_set[RX_POOL] = irq_mode & (rx_evt_i.fifo_level >= thr) &
                      (lvl_prev_reg < thr);
    tx_set[TX_BRK]  = brk_hit;
    tx_set[TX_BRKE] = in_brk_reg & rxd_s;
    tx_set[TX_ALL_SENT] = all_sent_now & ~all_sent_prev_reg;
    tx_set[TX_STOP] = rx_evt_i.char_valid & (rx_evt_i.char_data == stop_ch);
    tx_set[TX_TMR]  = tx_evt_i.timer_expired;
    tx_set[TX_CTS]  = cts_s ^ prev_reg[2];
    tx_set[TX_RES]  = rx_evt_i.char_valid & (rx_evt_i.char_data == res_ch);
    tx_set[TX_POOL] = tx_evt_i.pool_ready;
  end

  // status flags; a set in the clearing cycle wins
  always_comb begin
    rx_stat_next = rx_stat_reg;
    tx_stat_next = tx_stat_reg;
    if (rd_rx) begin
      rx_stat_next = 8'h00;
    end
    // vector output clears termination and pool full
    if (vec_ack_i.term) begin
      rx_stat_next[RX_TERM] = 1'b0;
    end
    if (vec_ack_i.receive_pool_full) begin
      rx_stat_next[RX_POOL] = 1'b0;
    end
    if (rd_tx) begin
      tx_stat_next = 8'h00;
    end
    // vector output clears transmit pool ready
    if (vec_ack_i.transmit_pool_ready) begin
      tx_stat_next[TX_POOL] = 1'b0;
    end
    rx_stat_next = rx_stat_next | rx_set;
    tx_stat_next = tx_stat_next | tx_set;
  end

  // status resets to zero, masks to ones
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_stat_reg <= STATUS_RST;
      tx_stat_reg <= STATUS_RST;
    end else begin
      rx_stat_reg <= rx_stat_next;
      tx_stat_reg <= tx_stat_next;
    end
  end

  // masked flags shown only with visibility set
  assign rx_vis = rx_stat_reg & (~rx_mask_reg | {8{masked_status_visible}});
  assign tx_vis = tx_stat_reg & (~tx_mask_reg | {8{masked_status_visible}});

  // writable registers, byte lanes honoured
  always_comb begin
    rx_mask_next = rx_mask_reg;
    tx_mask_next = tx_mask_reg;
    cfg_next     = cfg_reg;
    ccfg_next    = ccfg_reg;
    if (access_wr) begin
      unique case (paddr_i)
        RX_STATUS_ADDR: begin
          if (pstrb_i[0]) rx_mask_next = pwdata_i[7:0];
        end
        TX_STATUS_ADDR: begin
          if (pstrb_i[0]) tx_mask_next = pwdata_i[7:0];
        end
        CONFIG_ADDR: begin
          for (int b = 0; b < 4; b++) begin
            if (pstrb_i[b]) cfg_next[8*b +: 8] = pwdata_i[8*b +: 8];
          end
        end
        CHARCFG_ADDR: begin
          for (int b = 0; b < 4; b++) begin
            if (pstrb_i[b]) ccfg_next[8*b +: 8] = pwdata_i[8*b +: 8];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_mask_reg <= MASK_RST;
      tx_mask_reg <= MASK_RST;
      cfg_reg     <= CONFIG_RST;
      ccfg_reg    <= CHARCFG_RST;
    end else begin
      rx_mask_reg <= rx_mask_next;
      tx_mask_reg <= tx_mask_next;
      cfg_reg     <= cfg_next;
      ccfg_reg    <= ccfg_next;
    end
  end

  // read data and error captured in the setup phase
  always_comb begin
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (setup) begin
      rdata_next = 32'h0000_0000;
      err_next   = 1'b0;
      unique case (paddr_i)
        RX_STATUS_ADDR: rdata_next[7:0] = pwrite_i ? 8'h00 : rx_vis;
        TX_STATUS_ADDR: rdata_next[7:0] = pwrite_i ? 8'h00 : tx_vis;
        CONFIG_ADDR:    rdata_next      = cfg_reg;
        CHARCFG_ADDR:   rdata_next      = ccfg_reg;
        // carrier level, clear to send level, break state
        LINE_ADDR:      rdata_next[2:0] = {in_brk_reg, cts_s, cd_s};
        default:        err_next        = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
    end
  end

  assign prdata_o  = rdata_reg;
  assign pslverr_o = err_reg & psel_i & penable_i;

  // fifo status byte for the received character
  always_comb begin
    fstat_next = '0;
    // errors stored when status byte enabled
    if (rx_evt_i.char_valid && sbyte_en) begin
      fstat_next.valid       = 1'b1;
      fstat_next.parity_err  = par_en & rx_evt_i.parity_bad;
      fstat_next.framing_err = rx_evt_i.stop_zero;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fstat_reg <= '0;
    end else begin
      fstat_reg <= fstat_next;
    end
  end

  assign fifo_stat_o = fstat_reg;

  // idle reception and halt dpll-clocked transmit while unlocked
  assign rx_disable_o = dpll & rx_evt_i.pll_lost;
  assign tx_halt_o    = dpll & tx_dpll & rx_evt_i.pll_lost;

  // only unmasked flags reach interrupt and global status
  assign global_status_o = {|(tx_stat_reg & ~tx_mask_reg),
                            |(rx_stat_reg & ~rx_mask_reg)};
  assign irq_o = |global_status_o;
endmodule : asis_top
`default_nettype wire

/* asis_apb_host.sv */
/* apb master model that reads and writes the status block.
   assumes one clock; the answer is taken at the pready edge. */
`timescale 1ns/1ps
`default_nettype none
module asis_apb_host (
  input  wire logic                     clk_i,
  input  wire logic [31:0]              prdata_i,
  input  wire logic                     pready_i,
  input  wire logic                     pslverr_i,
  output logic                          psel_o,
  output logic                          penable_o,
  output logic                          pwrite_o,
  output logic [asis_pkg::PADDR_W-1:0]  paddr_o,
  output logic [31:0]                   pwdata_o
);
  import asis_pkg::*;
  // idle bus at time zero
  initial begin
    {psel_o, penable_o, pwrite_o} = 3'b000;
    paddr_o = '0;
    pwdata_o = '0;
  end
  // setup, then access held until pready is seen high
  task automatic xfer(input logic w, input logic [PADDR_W-1:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge clk_i);
    {psel_o, penable_o, pwrite_o} <= {2'b10, w};
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    // only the bench watchdog ends a wait for pready
    do begin
      @(posedge clk_i);
    end while (pready_i !== 1'b1);
    r = prdata_i;
    e = pslverr_i;
    // released lines show the inverse, not the old value
    {psel_o, penable_o} <= 2'b00;
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask : xfer
endmodule : asis_apb_host
`default_nettype wire

/* asis_top_props.sv */
/* port assertions for the interrupt status block.
   assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module asis_top_props (
  input wire logic                         clk_i,
  input wire logic                         rstn_i,
  input wire logic                         psel_i,
  input wire logic                         penable_i,
  input wire logic                         pwrite_i,
  input wire logic [asis_pkg::PADDR_W-1:0] paddr_i,
  input wire logic                         bit_tick_i,
  input wire logic                         rxd_i,
  input wire logic                         cd_i,
  input wire logic                         cts_i,
  input wire asis_pkg::asis_rx_evt_t       rx_evt_i,
  input wire asis_pkg::asis_tx_evt_t       tx_evt_i,
  input wire asis_pkg::asis_fifo_stat_t    fifo_stat_o,
  input wire logic                         rx_disable_o,
  input wire logic                         tx_halt_o,
  input wire logic [1:0]                   global_status_o,
  input wire logic                         irq_o
);
  import asis_pkg::*;
  logic acc_rd;
  logic mask_wr_reg;
  logic mask_wr_next;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // read access phase
  assign acc_rd = psel_i && penable_i && !pwrite_i;
  // remembers a mask write since reset
  always_comb begin
    mask_wr_next = mask_wr_reg;
    if (psel_i && penable_i && pwrite_i &&
        (paddr_i == RX_STATUS_ADDR || paddr_i == TX_STATUS_ADDR)) begin
      mask_wr_next = 1'b1;
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_wr_reg <= 1'b0;
    end else begin
      mask_wr_reg <= mask_wr_next;
    end
  end
  rst_quiet_a: assert property (disable iff (1'b0)
    !rstn_i |-> global_status_o == 2'b00 && !irq_o)
    else $error("flags not clear in reset");
  mask_rst_a: assert property (!mask_wr_reg |-> !irq_o)
    else $error("interrupt with reset masks");
  irq_or_a: assert property (irq_o == (|global_status_o))
    else $error("interrupt differs from global status");
  rx_clear_a: assert property (acc_rd && paddr_i == RX_STATUS_ADDR &&
    !rx_evt_i.char_valid && !rx_evt_i.frame_read_done && !bit_tick_i &&
    $stable(rx_evt_i) && cd_i == $past(cd_i, 6) |=> !global_status_o[0])
    else $error("receive flags survive a read");
  tx_clear_a: assert property (acc_rd && paddr_i == TX_STATUS_ADDR &&
    !tx_evt_i.timer_expired && !tx_evt_i.pool_ready && $stable(tx_evt_i) &&
    !rx_evt_i.char_valid && !bit_tick_i && cts_i == $past(cts_i, 6) &&
    rxd_i == $past(rxd_i, 6) |=> !global_status_o[1])
    else $error("line flags survive a read");
  par_src_a: assert property (fifo_stat_o.parity_err |->
    fifo_stat_o.valid && $past(rx_evt_i.char_valid && rx_evt_i.parity_bad))
    else $error("status byte parity without cause");
  frm_src_a: assert property (fifo_stat_o.valid |->
    $past(rx_evt_i.char_valid) &&
    fifo_stat_o.framing_err == $past(rx_evt_i.stop_zero))
    else $error("status byte framing mismatch");
  pll_gate_a: assert property (rx_disable_o |-> rx_evt_i.pll_lost)
    else $error("reception off while locked");
  halt_gate_a: assert property (tx_halt_o |-> rx_disable_o)
    else $error("transmit halt without lock loss");
endmodule : asis_top_props
bind asis_top asis_top_props i_props (
  .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .bit_tick_i(bit_tick_i),
  .rxd_i(rxd_i), .cd_i(cd_i), .cts_i(cts_i), .rx_evt_i(rx_evt_i),
  .tx_evt_i(tx_evt_i), .fifo_stat_o(fifo_stat_o),
  .rx_disable_o(rx_disable_o), .tx_halt_o(tx_halt_o),
  .global_status_o(global_status_o), .irq_o(irq_o));
`default_nettype wire

/* asis_top_tb.sv */
/* self-checking bench for the interrupt status block.
   assumes the host model for apb; events are driven by the bench. */
`timescale 1ns/1ps
`default_nettype none
module asis_top_tb;
  import asis_pkg::*;
  localparam logic [31:0] CFG  = 32'h1113_0a3f;
  localparam int          FLEN = CFG[11:8];
  logic                 clk_i    = 1'b0;
  logic                 rstn_i   = 1'b1;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [PADDR_W-1:0]   paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 bit_tick = 1'b0;
  logic                 rxd      = 1'b1;
  logic                 cd       = 1'b1;
  logic                 cts      = 1'b1;
  asis_rx_evt_t         rx_evt   = '0;
  asis_tx_evt_t         tx_evt   = '0;
  asis_vec_ack_t        vec_ack  = '0;
  asis_fifo_stat_t      fifo_stat;
  logic                 rx_dis;
  logic                 tx_halt;
  logic [1:0]           gstat;
  logic                 irq;
  logic [31:0]          lfsr     = 32'h554f40b5;
  logic [31:0]          rd_q;
  logic                 rd_e;
  int                   failures = 0;
  int                   samples_checked = 0;
  int                   rx_m     = 0;
  int                   tx_m     = 0;
  always #4 clk_i = ~clk_i;
  asis_apb_host i_host (.clk_i(clk_i), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
  asis_top i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .bit_tick_i(bit_tick), .rxd_i(rxd), .cd_i(cd),
    .cts_i(cts), .rx_evt_i(rx_evt), .tx_evt_i(tx_evt), .vec_ack_i(vec_ack),
    .fifo_stat_o(fifo_stat), .rx_disable_o(rx_dis), .tx_halt_o(tx_halt),
    .global_status_o(gstat), .irq_o(irq));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic rc(input logic [PADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    i_host.xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask : rc
  task automatic wr(input logic [PADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    i_host.xfer(1'b1, a, d, r, e);
  endtask : wr
  // status read against the model, which the read empties
  task automatic st(input bit t);
    rc(t ? TX_STATUS_ADDR : RX_STATUS_ADDR, t ? tx_m : rx_m);
    rx_m = t ? rx_m : 0;
    tx_m = t ? 0 : tx_m;
  endtask : st
  // one-cycle pulses: frame done, timer, pool, then xpr, rpf, term acks
  task automatic pulse(input logic [5:0] p);
    @(posedge clk_i);
    rx_evt.frame_read_done <= p[0];
    tx_evt.timer_expired <= p[1];
    tx_evt.pool_ready <= p[2];
    vec_ack <= p[5:3];
    @(posedge clk_i);
    rx_evt.frame_read_done <= 1'b0;
    {tx_evt.timer_expired, tx_evt.pool_ready} <= 2'b00;
    vec_ack <= 3'b000;
    @(negedge clk_i);
  endtask : pulse
  // one received character with parity, stop and full qualifiers
  task automatic chr(input logic [7:0] d, input logic [2:0] f);
    @(posedge clk_i);
    rx_evt.char_valid <= 1'b1;
    rx_evt.char_data <= d;
    {rx_evt.parity_bad, rx_evt.stop_zero, rx_evt.fifo_full} <= f;
    @(posedge clk_i);
    rx_evt.char_valid <= 1'b0;
    {rx_evt.parity_bad, rx_evt.stop_zero, rx_evt.fifo_full} <= 3'b000;
    @(negedge clk_i);
  endtask : chr
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i);
      bit_tick <= 1'b1;
      @(posedge clk_i);
      bit_tick <= 1'b0;
    end
    @(negedge clk_i);
  endtask : ticks
  task automatic print_verdict();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  // watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge clk_i);
    failures++;
    print_verdict();
  end
  initial begin
    rstn_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    st(0);
    st(1);
    i_host.xfer(1'b0, 10'h3fc, 32'h0, rd_q, rd_e);
    chk(rd_q, 32'h0);
    chk({31'h0, rd_e}, 32'h1);
    $display("test reset done");
    pulse(6'h02);
    st(1);
    chk({31'h0, irq}, 32'h0);
    wr(CONFIG_ADDR, CFG);
    pulse(6'h02);
    chk({31'h0, irq}, 32'h0);
    tx_m = 1 << TX_TMR;
    st(1);
    st(1);
    wr(RX_STATUS_ADDR, 32'h0);
    wr(TX_STATUS_ADDR, 32'h0);
    $display("test mask done");
    for (int k = 0; k < 3; k++) begin
      lfsr = nxt(lfsr);
      chr({2'b01, lfsr[5:0]}, 3'b100 >> k);
      chk({31'h0, irq}, 32'h1);
      rx_m = 1 << (k == 0 ? RX_PARITY_ERROR_FLAG : k == 1 ? RX_FRAMING_ERROR_FLAG : RX_OVF);
      st(0);
    end
    st(0);
    chr(CFG[23:16], 3'b000);
    tx_m = 1 << TX_STOP;
    st(1);
    chr(CFG[31:24], 3'b000);
    tx_m = 1 << TX_RES;
    st(1);
    @(posedge clk_i);
    rx_evt.fifo_level <= CHARCFG_RST[13:8] - 6'd1;
    @(posedge clk_i);
    rx_evt.fifo_level <= CHARCFG_RST[13:8];
    pulse(6'h01);
    rx_m = (1 << RX_TERM) | (1 << RX_POOL);
    st(0);
    @(posedge clk_i);
    rx_evt.fifo_level <= 6'd0;
    cd <= 1'b0;
    @(posedge clk_i);
    rx_evt.fifo_level <= CHARCFG_RST[13:8];
    pulse(6'h01);
    repeat (8) @(posedge clk_i);
    pulse(6'h30);
    rx_m = 1 << RX_CD;
    st(0);
    pulse(6'h06);
    pulse(6'h08);
    tx_m = 1 << TX_TMR;
    st(1);
    pulse(6'h04);
    tx_m = 1 << TX_POOL;
    st(1);
    @(posedge clk_i);
    cts <= 1'b0;
    repeat (8) @(posedge clk_i);
    rc(LINE_ADDR, 32'h0);
    tx_m = 1 << TX_CTS;
    st(1);
    {cd, cts} <= 2'b11;
    repeat (8) @(posedge clk_i);
    rc(LINE_ADDR, 32'h3);
    rx_m = 1 << RX_CD;
    st(0);
    tx_m = 1 << TX_CTS;
    st(1);
    {tx_evt.fifo_empty, tx_evt.shift_idle} <= 2'b11;
    tx_m = 1 << TX_ALL_SENT;
    st(1);
    rx_evt.pll_lost <= 1'b1;
    @(negedge clk_i);
    chk({30'h0, rx_dis, tx_halt}, 32'h3);
    rx_m = 1 << RX_PLL;
    st(0);
    rx_evt.pll_lost <= 1'b0;
    // parity check and interrupt mode off, termination character on
    wr(CONFIG_ADDR, CFG & 32'hffff_fff5);
    rx_evt.fifo_level <= 6'd0;
    wr(CHARCFG_ADDR, 32'h0001_202a);
    rx_evt.fifo_level <= CHARCFG_RST[13:8];
    chr(8'h2a, 3'b100);
    rx_m = 1 << RX_TERM;
    st(0);
    $display("test events done");
    chr({2'b01, lfsr[9:4]}, 3'b000);
    ticks(TIMEOUT_FRAMES * FLEN - 1);
    chk({30'h0, gstat}, 32'h0);
    ticks(1);
    chk({30'h0, gstat}, 32'h1);
    rx_m = 1 << RX_TOUT;
    st(0);
    @(posedge clk_i);
    rxd <= 1'b0;
    repeat (6) @(posedge clk_i);
    ticks(FLEN - 2);
    chk({30'h0, gstat}, 32'h0);
    ticks(1);
    chk({30'h0, gstat}, 32'h2);
    tx_m = 1 << TX_BRK;
    st(1);
    rxd <= 1'b1;
    repeat (8) @(posedge clk_i);
    tx_m = 1 << TX_BRKE;
    st(1);
    $display("test line done");
    print_verdict();
  end
endmodule : asis_top_tb
`default_nettype wire
